// ### hw/epi_ext_irq.sv
// External pin interrupt unit: sense decode, enable mask and pending flags
//
// Behaviour
// - Upper sense register, four two-bit fields, reset zero
// - Upper request needs global flag and enable bit
// - Sample upper pins on clock before edge detection
// - Level request asserted while pin stays low
// - Upper codes: low, change, fall, rise
// - Eight-bit enable mask, one bit per line
// - Pin activity triggers even when pin drives
// - Edge or change sets line pending flag
// - Vector to handler, flag cleared on execution
// - Writing one clears flag, zero keeps it
// - Pending flag held zero in level sensing
// - Sleep with lower lines off gates buffers
// - Lower codes: low, reserved, fall, rise
// - Low levels wake without clock, lower edges
//
// Decided for this implementation: the register offsets and strobed register access.
`timescale 1ns/1ps
`default_nettype none

module epi_ext_irq (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_sys_rst,
   // Register bus
   input wire epi_pkg::epi_bus_req_t i_bus,
   output logic [7:0] o_rdata,
   // Request pins, read back from the pad even when driven
   input wire logic [7:0] i_ext_request_pins,
   // CPU side
   input wire logic i_global_ie,
   input wire epi_pkg::epi_ack_t i_ack,
   input wire logic i_sleep_entry,
   output logic o_irq,
   output logic [7:0] o_line_request,
   output logic [2:0] o_vector_line,
   output logic o_wake_request
);
   import epi_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // Helper functions
   // Kept as functions so the sampler path and the wake path decode alike

   // Level mode test, shared by both groups
   function automatic logic is_level(input logic [1:0] code);
      is_level = (code == EPI_SENSE_LOW);
   endfunction

   // Edge or change hit between two consecutive samples
   function automatic logic sense_hit(input logic [1:0] code,
                                      input logic upper,
                                      input logic prev,
                                      input logic cur);
      logic hit;
      hit = 1'b0;
      case (code)
         EPI_SENSE_CHANGE: begin
            // Change only exists for the upper group
            hit = upper && (prev != cur);
         end
         EPI_SENSE_FALL: begin
            hit = prev && !cur;
         end
         EPI_SENSE_RISE: begin
            hit = !prev && cur;
         end
         default: begin
            // Low level never produces a flag
            hit = 1'b0;
         end
      endcase
      sense_hit = hit;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Registers

   // Lower sense control, fields as upper but code 01 reserved
   logic [7:0] lower_line_sense_control_ff;
   // Upper sense control, bits 7..0 hold lines 7..4
   logic [7:0] upper_line_sense_control_ff;
   // Per-line enable mask
   logic [7:0] line_enable_mask_ff;
   // Sticky pending flags, write one to clear
   logic [7:0] line_pending_bits_ff;
   // Read data, stands one cycle after the strobe
   logic [7:0] rdata_ff;
   // Synchroniser first stage, read only by the second stage
   logic [7:0] pin_meta_ff;
   // Synchronised pin level
   logic [7:0] pin_sync_ff;
   // Previous synchronised sample, for edge compare
   logic [7:0] pin_prev_ff;
   // Lower input buffers disabled during sleep, only when all four lower lines are masked
   logic buf_off_ff;
   // Registered request outputs
   logic [7:0] line_request_ff;
   logic [2:0] vector_line_ff;

   ////////////////////////////////////////////////////////////////////////
   // Address decode

   // Write strobes per register; unmapped offsets raise no strobe
   wire wr_lower = i_bus.wr && (i_bus.addr == EPI_OFF_LOWER_SENSE);
   wire wr_upper = i_bus.wr && (i_bus.addr == EPI_OFF_UPPER_SENSE);
   wire wr_mask = i_bus.wr && (i_bus.addr == EPI_OFF_ENABLE_MASK);
   wire wr_pend = i_bus.wr && (i_bus.addr == EPI_OFF_PENDING);

   // Read mux, unmapped offsets answer zero
   logic [7:0] rd_mux;
   always_comb begin
      case (i_bus.addr)
         EPI_OFF_LOWER_SENSE: begin
            rd_mux = lower_line_sense_control_ff;
         end
         EPI_OFF_UPPER_SENSE: begin
            rd_mux = upper_line_sense_control_ff;
         end
         EPI_OFF_ENABLE_MASK: begin
            rd_mux = line_enable_mask_ff;
         end
         EPI_OFF_PENDING: begin
            rd_mux = line_pending_bits_ff;
         end
         EPI_OFF_PIN_STATE: begin
            // Sampled pin levels, shows the block's view of the pads
            // Read only; a write to this offset is ignored
            rd_mux = pin_sync_ff;
         end
         default: begin
            rd_mux = EPI_RD_ZERO;
         end
      endcase
   end

   // Read data capture; zero outside a read cycle
   wire [7:0] nxt_rdata = i_bus.rd ? rd_mux : EPI_RD_ZERO;

   ////////////////////////////////////////////////////////////////////////
   // Control registers

   // Sense and mask registers, plain read/write
   // Read data drops to zero outside a read so an OR-ed bus stays clean
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         lower_line_sense_control_ff <= EPI_RST_SENSE;
         upper_line_sense_control_ff <= EPI_RST_SENSE;
         line_enable_mask_ff <= EPI_RST_MASK;
         rdata_ff <= EPI_RD_ZERO;
      end else begin
         if (wr_lower) begin
            lower_line_sense_control_ff <= i_bus.wdata;
         end
         if (wr_upper) begin
            upper_line_sense_control_ff <= i_bus.wdata;
         end
         if (wr_mask) begin
            line_enable_mask_ff <= i_bus.wdata;
         end
         rdata_ff <= nxt_rdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Sleep buffer gating

   // Lower buffers go off at sleep entry only when all four are disabled.
   // A disabled buffer reads high, so a low pin shows a rising change.
   // Gating follows the strobe level: on wake the view returns to the
   // pads, and a falling-coded lower line may flag once more.
   wire lower_all_off = ((line_enable_mask_ff & EPI_LOWER_LINES) == 8'h00);
   wire nxt_buf_off = i_sleep_entry ? lower_all_off : 1'b0;

   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         buf_off_ff <= 1'b0;
      end else begin
         buf_off_ff <= nxt_buf_off;
      end
   end

   // Internal pin view; pads read even when driven as outputs
   wire [7:0] pin_view = buf_off_ff ?
                         (i_ext_request_pins | EPI_LOWER_LINES) :
                         i_ext_request_pins;

   ////////////////////////////////////////////////////////////////////////
   // Pin sampling

   // Two-stage synchroniser, then one more stage for edge compare.
   // Idle value is high so a pin high at reset release is not an edge.
   // Only the second stage reads the first, so no unsettled value fans out.
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         pin_meta_ff <= EPI_PIN_IDLE;
         pin_sync_ff <= EPI_PIN_IDLE;
         pin_prev_ff <= EPI_PIN_IDLE;
      end else begin
         pin_meta_ff <= pin_view;
         pin_sync_ff <= pin_meta_ff;
         pin_prev_ff <= pin_sync_ff;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Per-line decode

   // Both sense registers side by side: line i always owns bits
   // 2i+1..2i, which keeps one indexing rule for the whole loop and
   // avoids a second hand-kept offset for the upper group.
   wire [2*EPI_LINES-1:0] line_code =
      {upper_line_sense_control_ff, lower_line_sense_control_ff};

   // Sense code, level flag and edge hit per line
   logic [7:0] line_level;
   logic [7:0] line_hit;
   always_comb begin
      line_level = 8'h00;
      line_hit = 8'h00;
      for (int i = 0; i < EPI_LINES; i++) begin
         if (i >= EPI_UPPER_BASE) begin
            line_level[i] =
               is_level(line_code[2*i +: 2]);
            line_hit[i] =
               sense_hit(line_code[2*i +: 2], 1'b1,
                         pin_prev_ff[i], pin_sync_ff[i]);
         end else begin
            line_level[i] =
               is_level(line_code[2*i +: 2]);
            // Reserved code 01 gives no hit for the lower group
            line_hit[i] =
               sense_hit(line_code[2*i +: 2], 1'b0,
                         pin_prev_ff[i], pin_sync_ff[i]);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Pending flags

   // Clear sources: write of ones, and handler acknowledge
   wire [7:0] w1c_mask = wr_pend ? i_bus.wdata : 8'h00;
   wire [7:0] ack_mask = i_ack.ack ? (8'h01 << i_ack.line) : 8'h00;

   // A hit in the clearing cycle wins; level lines are forced to zero.
   // Set-wins means an edge that lands beside a clear is never lost;
   // software simply finds the flag still up on its next read.
   wire [7:0] nxt_pending =
      ((line_pending_bits_ff & ~w1c_mask & ~ack_mask) | line_hit)
      & ~line_level;

   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         line_pending_bits_ff <= EPI_RST_PENDING;
      end else begin
         line_pending_bits_ff <= nxt_pending;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Request generation

   // Level lines request for as long as the sampled pin stays low.
   // Pulses shorter than the instruction in flight may be missed.
   wire [7:0] level_req = line_level & ~pin_sync_ff;
   wire [7:0] source_req = level_req | line_pending_bits_ff;
   // Each line gated by its enable bit and the global flag
   wire [7:0] nxt_line_request = i_global_ie ?
      (source_req & line_enable_mask_ff) : 8'h00;

   // Lowest line number has the highest priority.
   // Zero also means none; a low o_irq tells the two apart.
   logic [2:0] nxt_vector;
   always_comb begin
      nxt_vector = EPI_IDX_NONE;
      for (int i = EPI_LINES - 1; i >= 0; i--) begin
         if (nxt_line_request[i]) begin
            nxt_vector = i[2:0];
         end
      end
   end

   // Registered outputs cost one cycle of latency but keep the request
   // lines free of decode glitches.
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         line_request_ff <= 8'h00;
         vector_line_ff <= EPI_IDX_NONE;
      end else begin
         line_request_ff <= nxt_line_request;
         vector_line_ff <= nxt_vector;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Wake path

   // Works on raw pins with no clock: any enabled level line held low,
   // or an enabled lower edge line whose pin moved in its coded direction from its last
   // sample. The edge term needs the last sample held while asleep,
   // which is true because the sampler stops with the clock.
   // Raw pins mean a glitch shorter than a clock can still wake the
   // core; the clocked request path filters such glitches out.
   logic [7:0] wake_line;
   always_comb begin
      wake_line = 8'h00;
      for (int i = 0; i < EPI_LINES; i++) begin
         if (line_level[i]) begin
            wake_line[i] = !i_ext_request_pins[i];
         end else if (i < EPI_UPPER_BASE) begin
            wake_line[i] = sense_hit(lower_line_sense_control_ff[2*i +: 2],
                                     1'b0, pin_sync_ff[i],
                                     i_ext_request_pins[i]);
         end else begin
            wake_line[i] = 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs

   assign o_rdata = rdata_ff;
   assign o_line_request = line_request_ff;
   assign o_vector_line = vector_line_ff;
   // Level interrupt while any enabled line is requesting
   assign o_irq = |line_request_ff;
   // Combinational on purpose: no clock may run when a wake is needed
   assign o_wake_request = |(wake_line & line_enable_mask_ff);

   // Software must disable a line before retyping its sense field.
   // A new code is judged at once against samples already in flight,
   // so a pin that moved just before the write can flag straight away.
   // Nothing in this block masks that.

endmodule

`default_nettype wire

// ### hw/epi_pkg.sv
// Package: register map, field codes and bus carrier for the pin interrupt unit
package epi_pkg;

   // Widths
   localparam int unsigned EPI_LINES = 8;
   localparam int unsigned EPI_AW = 3;
   localparam int unsigned EPI_DW = 8;
   localparam int unsigned EPI_IDXW = 3;

   // Register offsets
   localparam logic [2:0] EPI_OFF_LOWER_SENSE = 3'h0;
   localparam logic [2:0] EPI_OFF_UPPER_SENSE = 3'h1;
   localparam logic [2:0] EPI_OFF_ENABLE_MASK = 3'h2;
   localparam logic [2:0] EPI_OFF_PENDING = 3'h3;
   localparam logic [2:0] EPI_OFF_PIN_STATE = 3'h4;

   // Reset values
   localparam logic [7:0] EPI_RST_SENSE = 8'h00;
   localparam logic [7:0] EPI_RST_MASK = 8'h00;
   localparam logic [7:0] EPI_RST_PENDING = 8'h00;
   localparam logic [7:0] EPI_RD_ZERO = 8'h00;

   // Line split: lines 3..0 lower group, 7..4 upper group
   localparam int unsigned EPI_UPPER_BASE = 4;
   localparam logic [7:0] EPI_LOWER_LINES = 8'h0F;
   localparam logic [7:0] EPI_PIN_IDLE = 8'hFF;

   // Sense codes
   localparam logic [1:0] EPI_SENSE_LOW = 2'h0;
   localparam logic [1:0] EPI_SENSE_CHANGE = 2'h1;
   localparam logic [1:0] EPI_SENSE_FALL = 2'h2;
   localparam logic [1:0] EPI_SENSE_RISE = 2'h3;

   // Vector index when nothing is requesting
   localparam logic [2:0] EPI_IDX_NONE = 3'h0;

   // Register bus request
   typedef struct packed {
      logic [EPI_AW-1:0] addr;
      logic [EPI_DW-1:0] wdata;
      logic wr;
      logic rd;
   } epi_bus_req_t;

   // Handler acknowledge from CPU vectoring logic
   typedef struct packed {
      logic ack;
      logic [EPI_IDXW-1:0] line;
   } epi_ack_t;

endpackage

// ### tb/epi_ext_irq_monitor.sv
// Checker: port-level properties of the pin interrupt unit
`timescale 1ns/1ps
`default_nettype none
module epi_ext_irq_monitor (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_sys_rst,
   // Watched ports
   input wire epi_pkg::epi_bus_req_t i_bus,
   input wire logic [7:0] o_rdata,
   input wire logic [7:0] i_ext_request_pins,
   input wire logic i_global_ie,
   input wire epi_pkg::epi_ack_t i_ack,
   input wire logic o_irq,
   input wire logic [7:0] o_line_request,
   input wire logic [2:0] o_vector_line
);
   import epi_pkg::*;
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_sys_rst);
   //////////////////////////////
   // Shadow copies of what software wrote
   logic [7:0] mask_ff, up_ff, lo_ff;
   logic [7:0] lvl_w; // Lines coded for low level
   logic rise7_w; // Line 7 enabled on rising edge
   assign rise7_w = mask_ff[7] && (up_ff[7:6] == EPI_SENSE_RISE);
   always_comb begin
      for (int k = 0; k < 4; k++) begin
         lvl_w[k] = lo_ff[2*k +: 2] == EPI_SENSE_LOW;
         lvl_w[k+4] = up_ff[2*k +: 2] == EPI_SENSE_LOW;
      end
   end
   // Track writes, same edge as the unit itself
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         mask_ff <= 8'h00;
         up_ff <= 8'h00;
         lo_ff <= 8'h00;
      end else if (i_bus.wr) begin
         if (i_bus.addr == EPI_OFF_ENABLE_MASK)
            mask_ff <= i_bus.wdata;
         if (i_bus.addr == EPI_OFF_UPPER_SENSE)
            up_ff <= i_bus.wdata;
         if (i_bus.addr == EPI_OFF_LOWER_SENSE)
            lo_ff <= i_bus.wdata;
      end
   end
   //////////////////////////////
   property p_irq_any;
      o_irq == (|o_line_request);
   endproperty
   a_irq_any: assert property (p_irq_any)
      else $error("irq differs from line requests");
   property p_gie_off;
      !i_global_ie |=> o_line_request == 8'h00;
   endproperty
   a_gie_off: assert property (p_gie_off)
      else $error("request without global flag");
   property p_mask_gate;
      (o_line_request & ~$past(mask_ff)) == 8'h00;
   endproperty
   a_mask_gate: assert property (p_mask_gate)
      else $error("request on a masked line");
   property p_vec_low;
      o_line_request != 8'h00 |-> o_line_request[o_vector_line] &&
         (o_line_request & ((8'h01 << o_vector_line) - 8'h01)) == 8'h00;
   endproperty
   a_vec_low: assert property (p_vec_low)
      else $error("vector is not the lowest requester");
   property p_level;
      (i_global_ie && mask_ff[4] && lvl_w[4] && !i_ext_request_pins[4])[*4]
         |-> o_line_request[4];
   endproperty
   a_level: assert property (p_level)
      else $error("low level gives no request");
   property p_edge;
      $rose(i_ext_request_pins[7]) && rise7_w && i_global_ie ##1
         (i_ext_request_pins[7] && rise7_w && i_global_ie)[*3]
         |-> ##[0:3] o_line_request[7];
   endproperty
   a_edge: assert property (p_edge)
      else $error("rising edge gives no request");
   property p_ack_clear;
      (rise7_w && $stable(i_ext_request_pins[7]))[*4] ##0
         (i_ack.ack && i_ack.line == 3'h7) |=> ##1 !o_line_request[7];
   endproperty
   a_ack_clear: assert property (p_ack_clear)
      else $error("handler execute leaves request");
   property p_rd_idle;
      !i_bus.rd |=> o_rdata == EPI_RD_ZERO;
   endproperty
   a_rd_idle: assert property (p_rd_idle)
      else $error("read data outside read slot");
   property p_pend_lvl;
      i_bus.rd && i_bus.addr == EPI_OFF_PENDING |=> (o_rdata & lvl_w) == 8'h00;
   endproperty
   a_pend_lvl: assert property (p_pend_lvl)
      else $error("flag set on a level line");
   c_ack: cover property (i_ack.ack && o_irq);
   c_lvl: cover property (o_line_request[4]);
   c_edge: cover property (o_line_request[7] && o_vector_line == 3'h7);
endmodule
bind epi_ext_irq epi_ext_irq_monitor u_mon (.i_clk(i_clk),
   .i_sys_rst(i_sys_rst), .i_bus(i_bus), .o_rdata(o_rdata),
   .i_ext_request_pins(i_ext_request_pins), .i_global_ie(i_global_ie),
   .i_ack(i_ack), .o_irq(o_irq), .o_line_request(o_line_request),
   .o_vector_line(o_vector_line));
`default_nettype wire

// ### tb/epi_far_model.sv
// Far-side model: request pin sources and CPU handler vectoring
`timescale 1ns/1ps
`default_nettype none
module epi_far_model (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_sys_rst,
   // Bench commands
   input wire logic [7:0] i_pin_level,
   input wire logic i_auto_ack,
   input wire logic [3:0] i_ack_delay,
   // Unit side
   input wire logic i_irq,
   input wire logic [2:0] i_vector_line,
   output logic [7:0] o_pins,
   output var epi_pkg::epi_ack_t o_ack
);
   import epi_pkg::*;
   logic [3:0] wait_ff; // Cycles the CPU has seen the request
   // Sources hold each level until told otherwise
   assign o_pins = i_pin_level;
   // Vector after a programmable delay, one execute pulse
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         wait_ff <= 4'h0;
         o_ack <= '0;
      end else begin
         o_ack.ack <= 1'b0;
         wait_ff <= 4'h0;
         if (i_auto_ack && i_irq && !o_ack.ack) begin
            wait_ff <= wait_ff + 4'h1;
            if (wait_ff == i_ack_delay) begin
               o_ack <= '{ack: 1'b1, line: i_vector_line};
               wait_ff <= 4'h0;
            end
         end
      end
   end
endmodule
`default_nettype wire

// ### tb/testbench.sv
// Testbench: registers, pin senses, vectoring and sleep of the unit
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import epi_pkg::*;
   logic i_clk, i_sys_rst, i_global_ie, i_sleep_entry, auto_ack;
   epi_bus_req_t i_bus;
   epi_ack_t ack;
   logic [7:0] pins, pin_level, o_rdata, o_line_request;
   logic [2:0] o_vector_line;
   logic o_irq, o_wake_request;
   int err_total, compares;
   // Free-running 100 MHz clock
   initial begin
      i_clk = 1'b0;
      forever #5 i_clk = ~i_clk;
   end
   epi_far_model u_far (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
      .i_pin_level(pin_level), .i_auto_ack(auto_ack), .i_ack_delay(4'h3),
      .i_irq(o_irq), .i_vector_line(o_vector_line), .o_pins(pins),
      .o_ack(ack));
   epi_ext_irq dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_bus(i_bus),
      .o_rdata(o_rdata), .i_ext_request_pins(pins),
      .i_global_ie(i_global_ie), .i_ack(ack), .i_sleep_entry(i_sleep_entry),
      .o_irq(o_irq), .o_line_request(o_line_request),
      .o_vector_line(o_vector_line), .o_wake_request(o_wake_request));
   //////////////////////////////
   task automatic print_verdict();
      $display("compares %0d mismatches %0d", compares, err_total);
      if (err_total == 0 && compares > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic chk(input string n, input logic [7:0] e,
                      input logic [7:0] g);
      compares++;
      if (g !== e) begin
         err_total++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask
   // One-cycle bus strobes, released at the next edge
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge i_clk);
      i_bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge i_clk);
      i_bus.wr <= 1'b0;
   endtask
   task automatic rd(input logic [2:0] a, input logic [7:0] e, input string n);
      @(posedge i_clk);
      i_bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge i_clk);
      i_bus.rd <= 1'b0;
      #1 chk(n, e, o_rdata);
   endtask
   task automatic pin(input logic [7:0] v);
      @(posedge i_clk);
      pin_level <= v;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge i_clk);
      #1;
   endtask
   // Bounded wait on the interrupt line
   task automatic wait_irq(input logic v);
      int n;
      n = 0;
      while (o_irq !== v && n < 50) begin
         @(posedge i_clk);
         #1;
         n++;
      end
      if (o_irq !== v) begin
         err_total++;
         print_verdict();
      end
   endtask
   //////////////////////////////
   initial begin
      i_sys_rst = 1'b1;
      i_bus = '0;
      pin_level = 8'hFF;
      i_global_ie = 1'b0;
      i_sleep_entry = 1'b0;
      auto_ack = 1'b0;
      err_total = 0;
      compares = 0;
      repeat (4) @(posedge i_clk);
      i_sys_rst <= 1'b0;
      rd(EPI_OFF_UPPER_SENSE, EPI_RST_SENSE, "upper");
      rd(EPI_OFF_ENABLE_MASK, EPI_RST_MASK, "mask");
      rd(EPI_OFF_PENDING, EPI_RST_PENDING, "pend");
      wr(3'h5, 8'hFF);
      rd(3'h5, EPI_RD_ZERO, "unmapped");
      rd(EPI_OFF_PIN_STATE, 8'hFF, "pins");
      wr(EPI_OFF_UPPER_SENSE, 8'hE4);
      rd(EPI_OFF_UPPER_SENSE, 8'hE4, "upper");
      wr(EPI_OFF_ENABLE_MASK, 8'hF0);
      rd(EPI_OFF_ENABLE_MASK, 8'hF0, "mask");
      $display("test registers done");
      // Codes per upper line: 4 low, 5 change, 6 fall, 7 rise
      @(posedge i_clk) i_global_ie <= 1'b1;
      pin(8'hBF);
      cyc(5);
      chk("req", 8'h40, o_line_request);
      chk("vec", 8'h06, {5'h0, o_vector_line});
      pin(8'h9F);
      cyc(5);
      pin(8'hBF);
      cyc(5);
      pin(8'h3F);
      cyc(5);
      rd(EPI_OFF_PENDING, 8'h60, "pend");
      pin(8'hBF);
      cyc(5);
      rd(EPI_OFF_PENDING, 8'hE0, "pend");
      wr(EPI_OFF_PENDING, 8'h20);
      rd(EPI_OFF_PENDING, 8'hC0, "pend");
      wr(EPI_OFF_PENDING, 8'h00);
      rd(EPI_OFF_PENDING, 8'hC0, "pend");
      pin(8'hAF);
      cyc(5);
      chk("req", 8'hD0, o_line_request);
      chk("vec", 8'h04, {5'h0, o_vector_line});
      rd(EPI_OFF_PENDING, 8'hC0, "pend");
      @(posedge i_clk) i_global_ie <= 1'b0;
      cyc(2);
      chk("irq", 8'h00, {7'h0, o_irq});
      @(posedge i_clk) i_global_ie <= 1'b1;
      pin(8'hBF);
      wr(EPI_OFF_ENABLE_MASK, 8'h00);
      cyc(2);
      chk("irq", 8'h00, {7'h0, o_irq});
      wr(EPI_OFF_PENDING, 8'hFF);
      rd(EPI_OFF_PENDING, 8'h00, "pend");
      wr(EPI_OFF_ENABLE_MASK, 8'hF0);
      $display("test upper senses done");
      // CPU takes the vector and executes the handler
      @(posedge i_clk) auto_ack <= 1'b1;
      pin(8'h3F);
      cyc(4);
      pin(8'hBF);
      wait_irq(1'b1);
      wait_irq(1'b0);
      rd(EPI_OFF_PENDING, 8'h00, "pend");
      $display("test vectoring done");
      // Lower codes: 0 rise, 1 reserved, 2 fall, 3 low
      @(posedge i_clk) auto_ack <= 1'b0;
      wr(EPI_OFF_ENABLE_MASK, 8'h00);
      wr(EPI_OFF_LOWER_SENSE, 8'h27);
      wr(EPI_OFF_PENDING, 8'hFF);
      wr(EPI_OFF_ENABLE_MASK, 8'h0F);
      pin(8'hB0);
      cyc(5);
      chk("req", 8'h0C, o_line_request);
      chk("wake", 8'h01, {7'h0, o_wake_request});
      pin(8'hBF);
      cyc(5);
      rd(EPI_OFF_PENDING, 8'h05, "pend");
      $display("test lower senses done");
      // Sleep with lower lines off turns their view high
      wr(EPI_OFF_ENABLE_MASK, 8'h00);
      wr(EPI_OFF_LOWER_SENSE, 8'hFF);
      pin(8'hB0);
      cyc(4);
      wr(EPI_OFF_PENDING, 8'hFF);
      @(posedge i_clk) i_sleep_entry <= 1'b1;
      cyc(5);
      rd(EPI_OFF_PENDING, 8'h0F, "pend");
      rd(EPI_OFF_PIN_STATE, 8'hBF, "pins");
      chk("wake", 8'h00, {7'h0, o_wake_request});
      $display("test sleep done");
      print_verdict();
   end
endmodule
`default_nettype wire
